// ===== verilog/sbsd_pkg.sv
`default_nettype none
package sbsd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_EVENT  = 8'h08;
  localparam logic [7:0] OFF_ACKIN  = 8'h0c;
  localparam logic [7:0] OFF_CMDOUT = 8'h10;

  // Control register field positions
  localparam int CTL_SI      = 0;
  localparam int CTL_ACK     = 1;
  localparam int CTL_ARBITRATION_LOST_FLAG = 2;
  localparam int CTL_ACKNOWLEDGE_REQUEST_FLAG   = 3;
  localparam int CTL_STOP    = 4;
  localparam int CTL_START   = 5;
  localparam int CTL_TRANSMIT_DIRECTION_FLAG  = 6;
  localparam int CTL_MASTER  = 7;

  // Status vector codes, ordered owner, direction, start, stop
  localparam logic [3:0] CODE_MT_START = 4'he;
  localparam logic [3:0] CODE_MT_BYTE  = 4'hc;
  localparam logic [3:0] CODE_MR_BYTE  = 4'h8;
  localparam logic [3:0] CODE_ST_BYTE  = 4'h4;
  localparam logic [3:0] CODE_ST_STOP  = 4'h5;
  localparam logic [3:0] CODE_SR_ADDR  = 4'h2;
  localparam logic [3:0] CODE_IDLE     = 4'h0;

  // Byte events reported by the shift engine
  typedef enum logic [2:0] {
    EV_NONE, EV_START_DONE, EV_MTX_BYTE, EV_MRX_BYTE,
    EV_STX_BYTE, EV_STX_ERROR, EV_STX_STOP, EV_SADDR
  } sbsd_event_t;

  // Actions handed to the shift engine when the event flag is cleared
  typedef enum logic [2:0] {
    ACT_NONE, ACT_SEND_DATA, ACT_RECEIVE, ACT_STOP,
    ACT_RESTART, ACT_STOP_START
  } sbsd_action_t;
endpackage : sbsd_pkg
`default_nettype wire

// ===== verilog/sbsd_decode.sv
`default_nettype none
// Maps an event into the status code and flags it presents
module sbsd_decode (
  // Event in
  input  wire sbsd_pkg::sbsd_event_t ev,
  input  wire logic                  was_master,
  // Status out
  output logic [3:0]                 code,
  output logic                       acknowledge_request_flag,
  output logic                       arbitration_lost_flag
);
  always_comb begin
    code    = sbsd_pkg::CODE_IDLE;
    acknowledge_request_flag   = 1'b0;
    arbitration_lost_flag = 1'b0;
    case (ev)
      sbsd_pkg::EV_START_DONE: code = sbsd_pkg::CODE_MT_START;
      sbsd_pkg::EV_MTX_BYTE:   code = sbsd_pkg::CODE_MT_BYTE;
      sbsd_pkg::EV_MRX_BYTE: begin
        code  = sbsd_pkg::CODE_MR_BYTE;
        acknowledge_request_flag = 1'b1;
      end
      sbsd_pkg::EV_STX_BYTE:   code = sbsd_pkg::CODE_ST_BYTE;
      sbsd_pkg::EV_STX_ERROR: begin
        code    = sbsd_pkg::CODE_ST_BYTE;
        arbitration_lost_flag = 1'b1;
      end
      sbsd_pkg::EV_STX_STOP:   code = sbsd_pkg::CODE_ST_STOP;
      sbsd_pkg::EV_SADDR: begin
        code    = sbsd_pkg::CODE_SR_ADDR;
        acknowledge_request_flag   = 1'b1;
        arbitration_lost_flag = was_master;
      end
      default: code = sbsd_pkg::CODE_IDLE;
    endcase
  end
endmodule : sbsd_decode
`default_nettype wire

// ===== verilog/sbsd_top.sv
`default_nettype none
module sbsd_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Shift engine side
  input  wire logic        ev_valid,
  input  wire logic [2:0]  ev_code,
  input  wire logic        ev_ack_in,
  input  wire logic [7:0]  ev_rx_byte,
  output logic             act_valid,
  output logic      [2:0]  act_code,
  output logic             act_ack_out,
  output logic      [7:0]  act_tx_byte,
  output logic             engine_busy
);
  typedef struct packed {
    logic [31:0]           rdata;
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic                  si;
    logic [3:0]            code;
    logic                  acknowledge_request_flag;
    logic                  arbitration_lost_flag;
    logic                  ack_in;
    logic                  ack_out;
    logic                  start_req;
    logic                  stop_req;
    logic [7:0]            data;
    logic                  data_written;
    logic                  master;
    sbsd_pkg::sbsd_event_t last_ev;
    logic                  act_valid;
    logic [2:0]            act_code;
    logic                  act_ack;
    logic [7:0]            act_byte;
    logic                  busy;
  } sbsd_state_t;

  sbsd_state_t q;
  sbsd_state_t d;

  sbsd_pkg::sbsd_event_t ev_in;
  logic [3:0]            dec_code;
  logic                  dec_acknowledge_request_flag;
  logic                  dec_arbitration_lost_flag;
  logic [7:0]            ctl_view;
  logic                  take_req;
  logic                  take_ev;

  assign ev_in    = sbsd_pkg::sbsd_event_t'(ev_code);
  assign take_req = hsel && hready && htrans[1];
  // Events only land while software is not holding the status
  assign take_ev  = ev_valid && !q.si && !q.act_valid;

  sbsd_decode u_decode (
    .ev         (ev_in),
    .was_master (q.master),
    .code       (dec_code),
    .acknowledge_request_flag      (dec_acknowledge_request_flag),
    .arbitration_lost_flag    (dec_arbitration_lost_flag)
  );

  always_comb begin
    // Status nibble sits above the flags in the control view
    ctl_view = {q.code, q.acknowledge_request_flag, q.arbitration_lost_flag, q.ack_out, q.si};
    // While the flag is set, written start and stop requests are ORed into bits 5 and 4, inside the code nibble
    if (q.si) begin
      ctl_view[sbsd_pkg::CTL_START] |= q.start_req;
      ctl_view[sbsd_pkg::CTL_STOP]  |= q.stop_req;
    end
    if (q.acknowledge_request_flag == 1'b0) begin
      ctl_view[sbsd_pkg::CTL_ACK] = q.ack_in;
    end
  end

  always_comb begin
    d           = q;
    d.act_valid = 1'b0;
    d.wr_pend   = 1'b0;

    // Address phase: capture writes, prepare read data one cycle later
    if (take_req) begin
      d.wr_pend = hwrite;
      d.wr_addr = haddr[7:0];
      d.rdata   = 32'h0;
      if (!hwrite) begin
        case (haddr[7:0])
          sbsd_pkg::OFF_CTRL:   d.rdata = {24'h0, ctl_view};
          sbsd_pkg::OFF_DATA:   d.rdata = {24'h0, q.data};
          sbsd_pkg::OFF_EVENT:  d.rdata = {29'h0, q.last_ev};
          sbsd_pkg::OFF_ACKIN:  d.rdata = {31'h0, q.ack_in};
          sbsd_pkg::OFF_CMDOUT: d.rdata = {28'h0, q.busy, q.act_code};
          default:              d.rdata = 32'h0;
        endcase
      end
    end

    // Data phase of a write
    if (q.wr_pend) begin
      case (q.wr_addr)
        sbsd_pkg::OFF_CTRL: begin
          d.start_req = hwdata[sbsd_pkg::CTL_START];
          d.stop_req  = hwdata[sbsd_pkg::CTL_STOP];
          d.ack_out   = hwdata[sbsd_pkg::CTL_ACK];
          // Clearing the event flag releases the engine with an action
          if (q.si && !hwdata[sbsd_pkg::CTL_SI]) begin
            d.si        = 1'b0;
            d.act_valid = 1'b1;
            d.busy      = 1'b1;
            d.act_ack   = hwdata[sbsd_pkg::CTL_ACK];
            d.act_byte  = q.data;
            d.act_code  = sbsd_pkg::ACT_NONE;
            if (hwdata[sbsd_pkg::CTL_START] && hwdata[sbsd_pkg::CTL_STOP])
              d.act_code = sbsd_pkg::ACT_STOP_START;
            else if (hwdata[sbsd_pkg::CTL_STOP])
              d.act_code = sbsd_pkg::ACT_STOP;
            else if (hwdata[sbsd_pkg::CTL_START])
              d.act_code = sbsd_pkg::ACT_RESTART;
            else if (q.data_written)
              d.act_code = sbsd_pkg::ACT_SEND_DATA;
            else if (q.code == sbsd_pkg::CODE_MT_BYTE && q.ack_in)
              d.act_code = sbsd_pkg::ACT_RECEIVE;
            else if (q.code == sbsd_pkg::CODE_MR_BYTE ||
                     q.code == sbsd_pkg::CODE_SR_ADDR)
              d.act_code = sbsd_pkg::ACT_RECEIVE;
            else
              d.act_code = sbsd_pkg::ACT_NONE;
            d.data_written = 1'b0;
          end
        end
        sbsd_pkg::OFF_DATA: begin
          // Writes while the engine shifts would corrupt the byte
          if (q.si) begin
            d.data         = hwdata[7:0];
            d.data_written = 1'b1;
          end
        end
        default: d.data = d.data;
      endcase
    end

    // A new event latches status; it is refused while the flag is set
    if (take_ev) begin
      if (ev_in != sbsd_pkg::EV_NONE) begin
        d.si        = 1'b1;
        d.busy      = 1'b0;
        d.last_ev   = ev_in;
        d.code      = dec_code;
        d.acknowledge_request_flag     = dec_acknowledge_request_flag;
        d.arbitration_lost_flag   = dec_arbitration_lost_flag;
        d.ack_in    = ev_ack_in;
        d.data      = ev_rx_byte;
        d.start_req = 1'b0;
        d.stop_req  = 1'b0;
        d.master    = dec_code[3];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hrdata      = q.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign act_valid   = q.act_valid;
  assign act_code    = q.act_code;
  assign act_ack_out = q.act_ack;
  assign act_tx_byte = q.act_byte;
  assign engine_busy = q.busy;
endmodule : sbsd_top
`default_nettype wire

// ===== sim/sbsd_top_asserts.sv
`default_nettype none
module sbsd_top_asserts (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Engine side
  input wire logic        ev_valid,
  input wire logic        act_valid,
  input wire logic [2:0]  act_code,
  input wire logic        engine_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_q;
  // Marks the data phase of a control read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_q <= 1'b0;
    else rd_q <= hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h00;
  end
  sequence s_rd;
    rd_q && hrdata[0];
  endsequence
  sequence s_st(logic [3:0] c);
    rd_q && hrdata[0] && hrdata[7:4] == c;
  endsequence
  a_act_one_cycle: assert property (act_valid |=> !act_valid)
    else $error("action pulse longer than one cycle");
  a_act_code_legal: assert property (act_valid |-> act_code <= 3'h5)
    else $error("action code out of range");
  a_busy_after_act: assert property (act_valid |-> ##[0:1] engine_busy)
    else $error("busy not raised by action");
  a_busy_end_event: assert property ($fell(engine_busy) |-> $past(ev_valid))
    else $error("busy dropped without event");
  a_code_listed: assert property (s_rd |-> hrdata[7:4] inside
    {4'he, 4'hc, 4'h8, 4'h4, 4'h5, 4'h2})
    else $error("unlisted status code");
  a_start_flags: assert property (s_st(4'he) |-> hrdata[3:2] == 2'b00)
    else $error("start status flags wrong");
  a_mtx_flags: assert property (s_st(4'hc) |-> hrdata[3:2] == 2'b00)
    else $error("master transmit flags wrong");
  a_mrx_flags: assert property (s_st(4'h8) |-> hrdata[3:2] == 2'b10)
    else $error("master receive flags wrong");
  a_stop_noreq: assert property (s_st(4'h5) |-> !hrdata[3])
    else $error("slave stop requests ack");
  a_saddr_req: assert property (s_st(4'h2) |-> hrdata[3])
    else $error("slave address without ack request");
endmodule : sbsd_top_asserts
bind sbsd_top sbsd_top_asserts u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .ev_valid, .act_valid, .act_code,
  .engine_busy);
`default_nettype wire

// ===== sim/sbsd_engine_model.sv
`default_nettype none
module sbsd_engine_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bench command
  input  wire logic       req,
  input  wire logic [2:0] req_code,
  input  wire logic       req_ack,
  // Event side
  output logic            ev_valid,
  output logic      [2:0] ev_code,
  output logic            ev_ack_in,
  output logic      [7:0] ev_rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle ack and byte lines toggle so a stale capture cannot pass for a fresh one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_valid   <= 1'b0;
      ev_code    <= 3'h0;
      ev_ack_in  <= 1'b0;
      ev_rx_byte <= 8'h00;
    end else if (req) begin
      ev_valid   <= 1'b1;
      ev_code    <= req_code;
      ev_ack_in  <= req_ack;
      ev_rx_byte <= 8'h5a ^ {5'h00, req_code};
    end else begin
      ev_valid   <= 1'b0;
      ev_code    <= 3'h0;
      ev_ack_in  <= ~ev_ack_in;
      ev_rx_byte <= ~ev_rx_byte;
    end
  end
endmodule : sbsd_engine_model
`default_nettype wire

// ===== sim/smbus_status_decode_tb_top.sv
`default_nettype none
module smbus_status_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        req = 1'b0;
  logic [2:0]  req_code = 3'h0;
  logic        req_ack = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hreadyout, hresp, ev_valid, ev_ack_in, act_valid, act_ack_out;
  logic        engine_busy;
  logic [2:0]  ev_code, act_code;
  logic [7:0]  ev_rx_byte, act_tx_byte;
  int          fails = 0;
  int          num_checks = 0;
  always #50 hclk = ~hclk;
  sbsd_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ev_valid, .ev_code, .ev_ack_in, .ev_rx_byte, .act_valid, .act_code,
    .act_ack_out, .act_tx_byte, .engine_busy);
  sbsd_engine_model eng (.hclk, .hresetn, .req, .req_code, .req_ack,
    .ev_valid, .ev_code, .ev_ack_in, .ev_rx_byte);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, e, m);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      wrap_up();
    end
  endtask : hold
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hold();
    r = hrdata;
  endtask : ahb
  // Event, status read, optional data write, then clear with new bits
  task automatic step(input logic [2:0] ev, input logic ai,
    input logic [7:0] st, input logic dw, input logic [7:0] cw,
    input logic [2:0] ea);
    logic [7:0] b;
    int n;
    b = 8'h5a ^ {5'h00, ev};
    req <= 1'b1;
    req_code <= ev;
    req_ack <= ai;
    @(posedge hclk);
    req <= 1'b0;
    repeat (3) @(posedge hclk);
    ahb(1'b0, sbsd_pkg::OFF_CTRL, 32'h0);
    chk(r, {24'h0, st}, st[3] ? 32'hfd : 32'hff);
    if (ev == 3'h3) begin
      ahb(1'b0, sbsd_pkg::OFF_DATA, 32'h0);
      chk(r, {24'h0, b}, 32'hff);
    end
    if (dw) ahb(1'b1, sbsd_pkg::OFF_DATA, {24'h0, ~b});
    ahb(1'b1, sbsd_pkg::OFF_CTRL, {24'h0, cw});
    n = 0;
    #1;
    while (act_valid !== 1'b1 && n < 8) begin
      @(posedge hclk);
      #1;
      n++;
    end
    chk({engine_busy, act_valid, act_ack_out, act_code},
        {2'b11, cw[1], ea}, 32'h3f);
    if (dw) chk(act_tx_byte, ~b, 32'hff);
    @(posedge hclk);
  endtask : step
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, sbsd_pkg::OFF_CTRL, 32'h0);
    chk(r, 32'h0, 32'hff);
    chk({30'h0, hreadyout, hresp}, 32'h2, 32'h3);
    ahb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h0, 32'hffffffff);
    step(3'h7, 1'b0, 8'h29, 1'b0, 8'h02, 3'h2);
    step(3'h1, 1'b0, 8'he1, 1'b1, 8'h00, 3'h1);
    step(3'h2, 1'b0, 8'hc1, 1'b0, 8'h20, 3'h4);
    step(3'h2, 1'b0, 8'hc1, 1'b0, 8'h10, 3'h3);
    step(3'h2, 1'b1, 8'hc3, 1'b0, 8'h30, 3'h5);
    step(3'h2, 1'b1, 8'hc3, 1'b1, 8'h00, 3'h1);
    step(3'h2, 1'b1, 8'hc3, 1'b0, 8'h20, 3'h4);
    step(3'h7, 1'b0, 8'h2d, 1'b0, 8'h00, 3'h2);
    step(3'h2, 1'b1, 8'hc3, 1'b0, 8'h10, 3'h3);
    step(3'h2, 1'b1, 8'hc3, 1'b0, 8'h00, 3'h2);
    step(3'h3, 1'b0, 8'h89, 1'b0, 8'h02, 3'h2);
    step(3'h3, 1'b0, 8'h89, 1'b0, 8'h10, 3'h3);
    step(3'h3, 1'b0, 8'h89, 1'b0, 8'h30, 3'h5);
    step(3'h3, 1'b0, 8'h89, 1'b0, 8'h22, 3'h4);
    step(3'h3, 1'b0, 8'h89, 1'b0, 8'h20, 3'h4);
    step(3'h3, 1'b0, 8'h89, 1'b1, 8'h02, 3'h1);
    step(3'h4, 1'b0, 8'h41, 1'b0, 8'h00, 3'h0);
    step(3'h4, 1'b1, 8'h43, 1'b1, 8'h00, 3'h1);
    step(3'h6, 1'b0, 8'h51, 1'b0, 8'h00, 3'h0);
    step(3'h5, 1'b0, 8'h45, 1'b0, 8'h00, 3'h0);
    // A second event while the flag is set must not disturb the status
    req <= 1'b1;
    req_code <= 3'h2;
    req_ack <= 1'b1;
    @(posedge hclk);
    req_code <= 3'h7;
    repeat (3) @(posedge hclk);
    req <= 1'b0;
    ahb(1'b0, sbsd_pkg::OFF_CTRL, 32'h0);
    chk(r, 32'hc3, 32'hff);
    wrap_up();
  end
endmodule : smbus_status_decode_tb_top
`default_nettype wire
